// File: logic/jmd_decode.sv
// Link mode parameter decoder with register port and sample order generator
// Notes on behaviour
// - One mode number chosen by software sets all other transport parameters; here streams and K have registers of their own.
// - A clock ratio of one half selects dual-edge input with two samples per clock.
// - Otherwise the ratio equals the interpolation factor 1..256; double-rate output leaves it.
// - Active lanes are ceiling(streams times the mode's maximum lanes / max streams), streams capped at max streams.
// - An interleave factor of one maps samples linearly from 0 to S-1.
// - A larger factor steps by the factor from 0, each pass starting one index higher.
// - In 8b/10b the frames per multiframe must be one of the mode's legal values.
// - Multiframe length must be a multiple of 64 characters, or 32 when K=32 and F=1.
// - Control words per frame and control bits per sample are both zero.
// - The configuration checksum is the sum of the preceding fields modulo 256.
// - Configuration octets received during alignment are ignored and never compared.
// - The octets-per-frame field is eight bits giving octets per frame per lane.
// - In 64b/66b there is exactly one multiblock per extended multiblock.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module jmd_decode
	import jmd_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [3:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [15:0] rdata_out,
	input  wire logic       ilas_valid_in,
	input  wire logic [7:0] ilas_octet_in,
	output logic            map_valid_out,
	input  wire logic       map_ready_in,
	output logic      [7:0] map_index_out,
	output logic      [4:0] active_lanes_out,
	output logic            dual_edge_out,
	output logic            config_ok_out
);
	// Mode table row
	typedef struct packed {
		logic [4:0] lx;
		logic [7:0] mx;
		logic [7:0] f;
		logic [7:0] s;
		logic       hd;
		logic [4:0] si;
		logic [4:0] n;
		logic [8:0] kmin;
	} jmd_row_s;

	// Per-mode constants; legal K is kmin, 2*kmin, 4*kmin
	function automatic jmd_row_s mode_row(input logic [3:0] m);
		jmd_row_s r;
		r = '{lx:5'h10, mx:8'h01, f:8'h02, s:8'h10, hd:1'b0, si:5'h01, n:5'h10, kmin:9'h020};
		unique case (m)
			4'h0: r = '{5'h10, 8'h01, 8'h02, 8'h10, 1'b0, 5'h01, 5'h10, 9'h020};
			4'h1: r = '{5'h10, 8'h02, 8'h02, 8'h08, 1'b0, 5'h01, 5'h10, 9'h020};
			4'h2: r = '{5'h10, 8'h04, 8'h02, 8'h04, 1'b0, 5'h01, 5'h10, 9'h020};
			4'h3: r = '{5'h10, 8'h08, 8'h02, 8'h02, 1'b0, 5'h01, 5'h10, 9'h020};
			4'h4: r = '{5'h08, 8'h08, 8'h02, 8'h01, 1'b0, 5'h01, 5'h10, 9'h020};
			4'h5: r = '{5'h04, 8'h08, 8'h04, 8'h01, 1'b0, 5'h01, 5'h10, 9'h010};
			4'h6: r = '{5'h02, 8'h08, 8'h08, 8'h01, 1'b0, 5'h01, 5'h10, 9'h008};
			4'h7: r = '{5'h01, 8'h08, 8'h10, 8'h01, 1'b0, 5'h01, 5'h10, 9'h004};
			4'h8: r = '{5'h10, 8'h01, 8'h08, 8'h50, 1'b0, 5'h10, 5'h0C, 9'h008};
			4'h9: r = '{5'h0C, 8'h01, 8'h02, 8'h10, 1'b1, 5'h01, 5'h0C, 9'h020};
			4'hA: r = '{5'h10, 8'h02, 8'h08, 8'h28, 1'b0, 5'h08, 5'h0C, 9'h008};
			4'hB: r = '{5'h0C, 8'h02, 8'h02, 8'h08, 1'b1, 5'h01, 5'h0C, 9'h020};
			4'hC: r = '{5'h08, 8'h02, 8'h08, 8'h14, 1'b0, 5'h04, 5'h0C, 9'h008};
			default: r = r;
		endcase
		return r;
	endfunction : mode_row

	// Software registers
	logic [3:0]  mode_reg;
	logic [7:0]  streams_reg;
	logic [8:0]  interp_reg;
	logic [7:0]  km1_reg;
	logic [3:0]  ctrl_reg;
	logic [7:0]  csum_reg;
	logic [15:0] rdata_reg;
	jmd_row_s    row;
	logic [8:0]  k_frames;
	logic        enc_8b10b;
	logic        mode_ok;
	logic        k_legal;
	logic        k_multiple;
	logic [15:0] mf_chars;
	logic [4:0]  lanes;
	logic [8:0]  ratio;
	logic [7:0]  r_bits;

	// Mode decode drives every derived parameter except the clock ratio
	assign row       = mode_row(mode_reg);
	assign mode_ok   = (mode_reg < 4'(JMD_NUM_MODES));
	assign enc_8b10b = ~ctrl_reg[JMD_CTRL_ENC_BIT];
	assign k_frames  = {1'b0, km1_reg} + 9'h001;

	// Legal K set is three powers of two from the mode minimum
	assign k_legal = (k_frames == row.kmin) || (k_frames == {row.kmin[7:0], 1'b0})
		|| (k_frames == {row.kmin[6:0], 2'b00});
	// Multiframe characters against elastic buffer depth
	assign mf_chars   = 16'(k_frames) * 16'(row.f);
	assign k_multiple = ((k_frames == JMD_K_REDUCED) && (row.f == JMD_F_ONE))
		? (mf_chars % 16'(JMD_EB_DEPTH_RED) == 16'h0000)
		: (mf_chars % 16'(JMD_EB_DEPTH) == 16'h0000);
	// Limit checks apply to 8b/10b only; 64b/66b uses fixed E
	assign config_ok_out = mode_ok && (!enc_8b10b || (k_legal && k_multiple));

	// Active lanes: ceiling(M*Lx/Mx), streams capped at Mx; Mx is never zero
	always_comb begin
		logic [7:0]  m_eff;
		logic [13:0] lane_num;
		m_eff    = (streams_reg > row.mx) ? row.mx : streams_reg;
		lane_num = 14'(m_eff) * 14'(row.lx) + 14'(row.mx) - 14'h0001;
		lanes    = (m_eff == 8'h00) ? 5'h00 : 5'(lane_num / 14'(row.mx));
	end

	// Ratio: half in dual-edge input, else interpolation; double-rate output ignored
	assign dual_edge_out = ctrl_reg[JMD_CTRL_DUAL_EDGE_SINGLE_RATE_INPUT_BIT];
	assign ratio = dual_edge_out ? JMD_RATIO_HALF : interp_reg;
	// Bits per lane per clock, reported so the host can set the PLL
	assign r_bits = 8'(16'(row.n) * 16'(row.s) / 16'((row.lx == 5'h00) ? 5'h01 : row.lx));

	// Register writes; interpolation clamped to 1..256
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_reg    <= JMD_RST_MODE;
			streams_reg <= JMD_RST_STREAMS;
			interp_reg  <= JMD_RST_INTERP;
			km1_reg     <= JMD_RST_KM1;
			ctrl_reg    <= JMD_RST_CTRL;
		end else if (wr_in) begin
			unique case (addr_in)
				JMD_ADDR_MODE:    mode_reg    <= wdata_in[3:0];
				JMD_ADDR_STREAMS: streams_reg <= wdata_in[7:0];
				JMD_ADDR_INTERP: begin
					if (wdata_in[8:0] == 9'h000) begin
						interp_reg <= JMD_RST_INTERP;
					end else if (wdata_in[8:0] > 9'(JMD_INTERP_MAX)) begin
						interp_reg <= 9'(JMD_INTERP_MAX);
					end else begin
						interp_reg <= wdata_in[8:0];
					end
				end
				JMD_ADDR_KM1:     km1_reg     <= wdata_in[7:0];
				JMD_ADDR_CTRL:    ctrl_reg    <= wdata_in[3:0];
				default: ;
			endcase
		end
	end

	// Checksum over received configuration octets, kept for reading only
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			csum_reg <= 8'h00;
		end else if (wr_in && (addr_in == JMD_ADDR_CSUM_IN)) begin
			csum_reg <= 8'h00;
		end else if (ilas_valid_in) begin
			csum_reg <= csum_reg + ilas_octet_in;
		end
	end

	// Sample order generator feeding the FIFO
	jmd_map_e   map_state_reg;
	logic [7:0] idx_reg;
	logic [7:0] pass_reg;
	logic [7:0] placed_reg;
	logic       gen_valid;
	logic       gen_ready;
	logic [7:0] step;
	logic [8:0] idx_sum;

	assign gen_valid = (map_state_reg == JMD_MAP_RUN);
	assign step      = (row.si <= 5'h01) ? 8'h01 : 8'(row.si);
	assign idx_sum   = {1'b0, idx_reg} + {1'b0, step};

	// Restart after every write to the map register; back-pressure from the FIFO stalls it
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			map_state_reg <= JMD_MAP_IDLE;
			idx_reg       <= 8'h00;
			pass_reg      <= 8'h00;
			placed_reg    <= 8'h00;
		end else if (wr_in && (addr_in == JMD_ADDR_MAP)) begin
			map_state_reg <= JMD_MAP_RUN;
			idx_reg       <= 8'h00;
			pass_reg      <= 8'h00;
			placed_reg    <= 8'h00;
		end else begin
			unique case (map_state_reg)
				JMD_MAP_IDLE: ;
				JMD_MAP_RUN: begin
					if (gen_ready) begin
						placed_reg <= placed_reg + 8'h01;
						if (placed_reg + 8'h01 == row.s) begin
							map_state_reg <= JMD_MAP_IDLE;
						end else if (idx_sum >= {1'b0, row.s}) begin
							idx_reg  <= pass_reg + 8'h01;
							pass_reg <= pass_reg + 8'h01;
						end else begin
							idx_reg <= idx_sum[7:0];
						end
					end
				end
			endcase
		end
	end

	jmd_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (gen_valid),
		.in_ready_out  (gen_ready),
		.in_data_in    (idx_reg),
		.out_valid_out (map_valid_out),
		.out_ready_in  (map_ready_in),
		.out_data_out  (map_index_out)
	);

	// Lane output registered
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			active_lanes_out <= 5'h00;
		end else begin
			active_lanes_out <= lanes;
		end
	end

	// Read data one cycle after strobe, zero otherwise
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_reg <= 16'h0000;
		end else if (rd_in) begin
			unique case (addr_in)
				JMD_ADDR_MODE:    rdata_reg <= {12'h000, mode_reg};
				JMD_ADDR_STREAMS: rdata_reg <= {8'h00, streams_reg};
				JMD_ADDR_INTERP:  rdata_reg <= {7'h00, interp_reg};
				JMD_ADDR_KM1:     rdata_reg <= {8'h00, km1_reg};
				JMD_ADDR_CTRL:    rdata_reg <= {12'h000, ctrl_reg};
				JMD_ADDR_LANES:   rdata_reg <= {11'h000, lanes};
				JMD_ADDR_RATIO:   rdata_reg <= {7'h00, ratio};
				JMD_ADDR_STATUS:  rdata_reg <= {r_bits, JMD_E_FIXED[0], JMD_CS_FIXED,
					JMD_CF_FIXED[3:0], config_ok_out};
				JMD_ADDR_CSUM:    rdata_reg <= {8'h00, csum_reg};
				JMD_ADDR_MAP:     rdata_reg <= {row.f, 7'h00, gen_valid};
				default:          rdata_reg <= 16'h0000;
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end
	assign rdata_out = rdata_reg;

	// Checks
	property p_ratio_half;
		@(posedge clk_in) disable iff (rst_in) dual_edge_out |-> ratio == JMD_RATIO_HALF;
	endproperty
	a_ratio_half: assert property (p_ratio_half) else $error("ratio not half");
	property p_ratio_interp;
		@(posedge clk_in) disable iff (rst_in)
		!dual_edge_out |-> (ratio == interp_reg) && (ratio != 9'h000);
	endproperty
	a_ratio_interp: assert property (p_ratio_interp) else $error("ratio not interp");
	property p_lanes;
		@(posedge clk_in) disable iff (rst_in)
		(streams_reg >= row.mx) && mode_ok |=> active_lanes_out == $past(row.lx);
	endproperty
	a_lanes: assert property (p_lanes) else $error("full lanes wrong");
	property p_kplus;
		@(posedge clk_in) disable iff (rst_in)
		enc_8b10b && mode_ok && (km1_reg == 8'(row.kmin - 9'h001)) |-> config_ok_out;
	endproperty
	a_kplus: assert property (p_kplus) else $error("k offset wrong");
	property p_first_zero;
		@(posedge clk_in) disable iff (rst_in)
		wr_in && (addr_in == JMD_ADDR_MAP) |=> idx_reg == 8'h00;
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("map not at 0");
	property p_linear;
		@(posedge clk_in) disable iff (rst_in)
		gen_valid && gen_ready && (step == 8'h01) && (placed_reg + 8'h01 != row.s)
		&& !(wr_in && (addr_in == JMD_ADDR_MAP)) |=> idx_reg == $past(idx_reg) + 8'h01;
	endproperty
	a_linear: assert property (p_linear) else $error("linear step wrong");
	property p_csum;
		@(posedge clk_in) disable iff (rst_in)
		ilas_valid_in && !(wr_in && (addr_in == JMD_ADDR_CSUM_IN))
		|=> csum_reg == $past(csum_reg) + $past(ilas_octet_in);
	endproperty
	a_csum: assert property (p_csum) else $error("checksum wrong");
	property p_kbad;
		@(posedge clk_in) disable iff (rst_in)
		enc_8b10b && !k_legal |-> !config_ok_out;
	endproperty
	a_kbad: assert property (p_kbad) else $error("illegal K accepted");
	property p_rd_zero;
		@(posedge clk_in) disable iff (rst_in) !rd_in |=> rdata_out == 16'h0000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data stale");
	c_map_done: cover property (@(posedge clk_in) disable iff (rst_in)
		gen_valid ##1 !gen_valid);
	c_fifo_full: cover property (@(posedge clk_in) disable iff (rst_in)
		gen_valid && !gen_ready);
	c_dual: cover property (@(posedge clk_in) disable iff (rst_in) dual_edge_out);
	c_ok: cover property (@(posedge clk_in) disable iff (rst_in) config_ok_out);
endmodule : jmd_decode

// File: logic/jmd_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module jmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Handshakes from occupancy
	assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_out = (count_reg != '0);
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_data_out  = mem_reg[rd_ptr_reg];

	// Storage, no reset needed on data
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_in;
		end
	end

	// Pointers wrap at depth
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Occupancy never passes the depth
	property p_no_overflow;
		@(posedge clk_in) disable iff (rst_in) count_reg <= (AW+1)'(DEPTH);
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth");
endmodule : jmd_fifo

// File: shared/jmd_pkg.sv
// Package of constants and types for the link mode parameter decoder
package jmd_pkg;
	// Register offsets
	localparam logic [3:0] JMD_ADDR_MODE    = 4'h0;
	localparam logic [3:0] JMD_ADDR_STREAMS = 4'h1;
	localparam logic [3:0] JMD_ADDR_INTERP  = 4'h2;
	localparam logic [3:0] JMD_ADDR_KM1     = 4'h3;
	localparam logic [3:0] JMD_ADDR_CTRL    = 4'h4;
	localparam logic [3:0] JMD_ADDR_LANES   = 4'h5;
	localparam logic [3:0] JMD_ADDR_RATIO   = 4'h6;
	localparam logic [3:0] JMD_ADDR_STATUS  = 4'h7;
	localparam logic [3:0] JMD_ADDR_CSUM_IN = 4'h8;
	localparam logic [3:0] JMD_ADDR_CSUM    = 4'h9;
	localparam logic [3:0] JMD_ADDR_MAP     = 4'hA;
	// Field positions in the control register
	localparam int JMD_CTRL_DUAL_EDGE_SINGLE_RATE_INPUT_BIT = 0;
	localparam int JMD_CTRL_DUAL_EDGE_DOUBLE_RATE_OUTPUT_BIT = 1;
	localparam int JMD_CTRL_SCR_BIT   = 2;
	localparam int JMD_CTRL_ENC_BIT   = 3;
	// Reset values
	localparam logic [3:0] JMD_RST_MODE    = 4'h0;
	localparam logic [7:0] JMD_RST_STREAMS = 8'h01;
	localparam logic [8:0] JMD_RST_INTERP  = 9'h001;
	localparam logic [7:0] JMD_RST_KM1     = 8'h3F;
	localparam logic [3:0] JMD_RST_CTRL    = 4'h0;
	// Link constants
	localparam logic [4:0] JMD_CF_FIXED     = 5'h00;
	localparam logic [1:0] JMD_CS_FIXED     = 2'h0;
	localparam logic [7:0] JMD_E_FIXED      = 8'h01;
	localparam int         JMD_EB_DEPTH     = 64;
	localparam int         JMD_EB_DEPTH_RED = 32;
	localparam logic [8:0] JMD_K_REDUCED    = 9'h020;
	localparam logic [7:0] JMD_F_ONE        = 8'h01;
	localparam int         JMD_INTERP_MAX   = 256;
	localparam int         JMD_NUM_MODES    = 13;
	// Ratio encoding: 0 stands for one half (dual-edge input)
	localparam logic [8:0] JMD_RATIO_HALF   = 9'h000;

	typedef enum logic [1:0] {
		JMD_MAP_IDLE,
		JMD_MAP_RUN
	} jmd_map_e;
endpackage : jmd_pkg

// File: tb/jmd_decode_tb.sv
// Self-checking testbench for the link mode parameter decoder
`timescale 1ns/1ps
module jmd_decode_tb;
	import jmd_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [3:0]  addr_in = 4'h0;
	logic [15:0] wdata_in = 16'h0000;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        slow = 1'b0;
	logic [15:0] rdata_out;
	logic        ilas_valid_in, map_valid_out, map_ready_in, dual_edge_out, config_ok_out;
	logic [7:0]  ilas_octet_in, map_index_out;
	logic [4:0]  active_lanes_out;
	int          failures = 0;
	int          compares = 0;
	int          cyc = 0;

	jmd_decode #(.FIFO_DEPTH(4)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.ilas_valid_in(ilas_valid_in), .ilas_octet_in(ilas_octet_in),
		.map_valid_out(map_valid_out), .map_ready_in(map_ready_in),
		.map_index_out(map_index_out), .active_lanes_out(active_lanes_out),
		.dual_edge_out(dual_edge_out), .config_ok_out(config_ok_out));
	jmd_tx_model i_tx (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
		.map_valid_in(map_valid_out), .map_index_in(map_index_out), .map_ready_out(map_ready_in),
		.ilas_valid_out(ilas_valid_in), .ilas_octet_out(ilas_octet_in));

	// 10 MHz clock
	initial begin
		forever #50 clk_in = ~clk_in;
	end

	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict

	// Hang guard, far above the longest expected run
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : rd

	task automatic chk_reg(input string n, input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(n, d, exp);
	endtask : chk_reg

	// Status word: bit0 config ok, CF and CS fields fixed at zero
	task automatic chk_ok(input logic exp);
		logic [15:0] d;
		rd(JMD_ADDR_STATUS, d);
		chk("status", {9'h000, d[6:0]}, {15'h0000, exp});
		chk("config_ok_out", {15'h0000, config_ok_out}, {15'h0000, exp});
	endtask : chk_ok

	task automatic t_reset();
		chk_reg("mode", JMD_ADDR_MODE, 16'h0000);
		chk_reg("streams", JMD_ADDR_STREAMS, 16'h0001);
		chk_reg("interp", JMD_ADDR_INTERP, 16'h0001);
		chk_reg("km1", JMD_ADDR_KM1, 16'h003F);
		chk_reg("ctrl", JMD_ADDR_CTRL, 16'h0000);
		chk_reg("lanes", JMD_ADDR_LANES, 16'h0010);
		chk_reg("ratio", JMD_ADDR_RATIO, 16'h0001);
		chk_reg("status_word", JMD_ADDR_STATUS, 16'h1081);
		chk_reg("unmapped", 4'hF, 16'h0000);
		chk_ok(1'b1);
	endtask : t_reset

	// Lanes scale as ceiling(M*Lx/Mx), including counts that are not powers of two
	task automatic t_lanes();
		logic [3:0]  mv[5] = '{4'h2, 4'h2, 4'h2, 4'h3, 4'h6};
		logic [15:0] sv[5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0003, 16'h0001};
		logic [15:0] lv[5] = '{16'h0004, 16'h0008, 16'h0010, 16'h0006, 16'h0001};
		for (int i = 0; i < 5; i++) begin
			wr(JMD_ADDR_MODE, {12'h000, mv[i]});
			wr(JMD_ADDR_STREAMS, sv[i]);
			chk_reg("lanes", JMD_ADDR_LANES, lv[i]);
			chk("active_lanes_out", {11'h000, active_lanes_out}, lv[i]);
		end
	endtask : t_lanes

	// Ratio follows interpolation unless dual-edge input is on
	task automatic t_ratio();
		logic [15:0] iv[5] = '{16'h0100, 16'h0100, 16'h0100, 16'h0000, 16'h012C};
		logic [15:0] cv[5] = '{16'h0000, 16'h0002, 16'h0001, 16'h0000, 16'h0000};
		logic [15:0] ev[5] = '{16'h0100, 16'h0100, 16'h0000, 16'h0001, 16'h0100};
		for (int i = 0; i < 5; i++) begin
			wr(JMD_ADDR_INTERP, iv[i]);
			wr(JMD_ADDR_CTRL, cv[i]);
			chk_reg("ratio", JMD_ADDR_RATIO, ev[i]);
			chk("dual_edge_out", {15'h0000, dual_edge_out}, {15'h0000, cv[i][0]});
		end
	endtask : t_ratio

	// Frames per multiframe legality, stored as count minus one
	task automatic t_k();
		logic [3:0]  mv[7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h6, 4'h6};
		logic [15:0] kv[7] = '{16'h1F, 16'h3F, 16'h7F, 16'h0F, 16'h40, 16'h07, 16'h3F};
		logic        ov[7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		wr(JMD_ADDR_CTRL, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			wr(JMD_ADDR_MODE, {12'h000, mv[i]});
			wr(JMD_ADDR_KM1, kv[i]);
			chk_ok(ov[i]);
		end
		wr(JMD_ADDR_CTRL, 16'h0008);
		chk_ok(1'b1);
		wr(JMD_ADDR_MODE, 16'h000D);
		chk_ok(1'b0);
	endtask : t_k

	// Checksum of received octets; they never affect the ok flag
	task automatic t_csum();
		wr(JMD_ADDR_CTRL, 16'h0000);
		wr(JMD_ADDR_MODE, 16'h0000);
		wr(JMD_ADDR_KM1, 16'h3F);
		wr(JMD_ADDR_CSUM_IN, 16'h0000);
		i_tx.send_octet(8'h80);
		i_tx.send_octet(8'h90);
		i_tx.send_octet(8'h15);
		chk_reg("csum", JMD_ADDR_CSUM, 16'h0025);
		chk_ok(1'b1);
		wr(JMD_ADDR_CSUM_IN, 16'h0000);
		chk_reg("csum", JMD_ADDR_CSUM, 16'h0000);
	endtask : t_csum

	// Sample order through the FIFO, with the consumer stalling or not
	task automatic t_map(input logic [3:0] m, input int s, input int si, input logic sl,
		input logic [7:0] f);
		logic [7:0] exp[$];
		int         n;
		for (int p = 0; p < si; p++)
			for (int i = p; i < s; i += si) exp.push_back(i[7:0]);
		slow <= sl;
		wr(JMD_ADDR_MODE, {12'h000, m});
		i_tx.got.delete();
		wr(JMD_ADDR_MAP, 16'h0000);
		n = 0;
		while (i_tx.got.size() < s && n < 3000) begin
			@(posedge clk_in);
			n++;
		end
		repeat (6) @(posedge clk_in);
		chk("map_count", 16'(i_tx.got.size()), s[15:0]);
		chk("map_valid_out", {15'h0000, map_valid_out}, 16'h0000);
		for (int i = 0; i < s && i < i_tx.got.size(); i++)
			chk("map_index", {8'h00, i_tx.got[i]}, {8'h00, exp[i]});
		chk_reg("octets_per_frame", JMD_ADDR_MAP, {f, 8'h00});
	endtask : t_map

	// Main sequence
	initial begin
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_lanes();
		t_ratio();
		t_k();
		t_csum();
		t_map(4'h0, 16, 1, 1'b0, 8'h02);
		t_map(4'h8, 80, 16, 1'b1, 8'h08);
		t_map(4'hA, 40, 8, 1'b0, 8'h08);
		t_map(4'hC, 20, 4, 1'b1, 8'h08);
		give_verdict();
	end
endmodule : jmd_decode_tb

// File: tb/jmd_tx_model.sv
// Far-side transmitter model: sends alignment octets and drains the sample order
`timescale 1ns/1ps
module jmd_tx_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       slow_in,
	input  wire logic       map_valid_in,
	input  wire logic [7:0] map_index_in,
	output logic            map_ready_out,
	output logic            ilas_valid_out,
	output logic      [7:0] ilas_octet_out
);
	logic [7:0] got[$];
	logic [1:0] tick_reg;

	// Ready pattern; slow mode accepts one cycle in four so the FIFO fills
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_reg      <= 2'h0;
			map_ready_out <= 1'b0;
		end else begin
			tick_reg      <= tick_reg + 2'h1;
			map_ready_out <= !slow_in || (tick_reg == 2'h3);
		end
	end

	// Indices taken in arrival order, both ends agree on this mapping
	always @(posedge clk_in) begin
		if (!rst_in && map_valid_in && map_ready_out) got.push_back(map_index_in);
	end

	// Idle line shows A5, then the complement of the last octet, never the last octet
	initial begin
		ilas_valid_out = 1'b0;
		ilas_octet_out = 8'hA5;
	end

	// One configuration octet; its content is not the receiver's concern
	task automatic send_octet(input logic [7:0] o);
		@(posedge clk_in);
		ilas_valid_out <= 1'b1;
		ilas_octet_out <= o;
		@(posedge clk_in);
		ilas_valid_out <= 1'b0;
		ilas_octet_out <= ~o;
	endtask : send_octet
endmodule : jmd_tx_model
